// ==== rtl/icf_map.svh ====
// Purpose: register indices, bit positions and reset values of the
//          bus flag block
// Assumes: included by its bare name wherever these constants are used
// Notes:   a register index times four is its wishbone byte address
`ifndef ICF_MAP_SVH
`define ICF_MAP_SVH

// register indices (word address = index)
`define ICF_IDX_FLAG     16'hFFAB
`define ICF_IDX_CTRL     16'hFFAC
`define ICF_IDX_IRQ_STAT 16'hFFAD
`define ICF_IDX_IRQ_MASK 16'hFFAE

// flag register fields
`define ICF_FLAG_FAIL    7
`define ICF_FLAG_BUSY    6
`define ICF_FLAG_INITIAL_START_ENABLE_BIT   1
`define ICF_FLAG_RSV     0
`define ICF_FLAG_RST     8'h00

// control register fields
`define ICF_CTRL_EN      7
`define ICF_CTRL_STR     1
`define ICF_CTRL_RST     8'h00

// interrupt status and mask fields
`define ICF_IRQ_START    0
`define ICF_IRQ_STOP     1
`define ICF_IRQ_FAIL     2
`define ICF_IRQ_GEN      3
`define ICF_IRQ_RST      4'h0

`endif

// ==== rtl/icf_pkg.sv ====
// Purpose: types shared by the bus flag block
// Assumes: nothing
// Notes:   constants live in icf_map.svh
package icf_pkg;

   // conditions seen on the bus, one-cycle pulses
   typedef struct packed {
      logic start;
      logic stop;
   } icf_cond_t;

   // state of the condition detector
   typedef struct packed {
      logic      scl_m;
      logic      sda_m;
      logic      scl_s;
      logic      sda_s;
      logic      scl_p;
      logic      sda_p;
      icf_cond_t cond;
   } icf_det_state_t;

   // state of the flag block
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        fail;
      logic        busy;
      logic        initial_start_enable_bit;
      logic        rsv;
      logic        en;
      logic        str;
      logic        en_p;
      logic        gen;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic        irq;
   } icf_state_t;

endpackage : icf_pkg

// ==== rtl/icf_cond_det.sv ====
// Purpose: synchronise the bus lines and find start and stop conditions
// Assumes: scl and sda come from pins, asynchronous to clk_i
// Notes:   conditions come out one cycle after the synchronised edge
`timescale 1ns/1ps
`include "icf_map.svh"

module icf_cond_det (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // bus lines
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   // detected conditions
   output icf_pkg::icf_cond_t     cond_o
);

   icf_pkg::icf_det_state_t st;
   icf_pkg::icf_det_state_t next_st;

   // three flops per line; only the second stage and later are looked at
   always_comb begin
      next_st            = st;
      next_st.scl_m      = scl_i;
      next_st.sda_m      = sda_i;
      next_st.scl_s      = st.scl_m;
      next_st.sda_s      = st.sda_m;
      next_st.scl_p      = st.scl_s;
      next_st.sda_p      = st.sda_s;
      // sda falling while scl stays high is a start, rising is a stop
      next_st.cond.start = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
      next_st.cond.stop  = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
   end

   // idle bus is high on both lines, so reset to that to avoid a
   // false condition right after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
                 scl_p: 1'b1, sda_p: 1'b1, cond: '0};
      end else begin
         st <= next_st;
      end
   end

   assign cond_o = st.cond;

endmodule : icf_cond_det

// ==== rtl/icf_flags.sv ====
// Purpose: bus status and start flag logic of a two-wire bus controller
// Assumes: classic wishbone slave, 32-bit data, registers in lane 0
// Notes:   the start itself is made by the controller on start_gen_o;
//          this block decides when it may be made and keeps the flags
`timescale 1ns/1ps
`include "icf_map.svh"

module icf_flags #(
   parameter int ADR_W = 18
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [ADR_W-1:0]  adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // bus lines, observed only
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   // controller side
   output logic                   start_gen_o,
   output logic                   busy_o,
   output logic                   enable_o,
   // interrupt
   output logic                   irq_o
);

   icf_pkg::icf_state_t st;
   icf_pkg::icf_state_t next_st;
   icf_pkg::icf_cond_t  cond;

   logic [15:0] idx;
   logic        req;
   logic        wr;
   logic        hit_flag;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        hit_mask;
   logic [7:0]  wbyte;
   logic [3:0]  ev;
   logic [31:0] rd;
   logic        busy_now;

   // bus lines pass a two-flop synchroniser inside the detector
   icf_cond_det u_det (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .scl_i  (scl_i),
      .sda_i  (sda_i),
      .cond_o (cond)
   );

   // address decode; the request is taken once, in the cycle before ack
   always_comb begin
      idx      = 16'(adr_i[ADR_W-1:2]);
      req      = cyc_i & stb_i & ~st.ack;
      wr       = req & we_i & sel_i[0];
      wbyte    = dat_i[7:0];
      hit_flag = (idx == `ICF_IDX_FLAG);
      hit_ctrl = (idx == `ICF_IDX_CTRL);
      hit_stat = (idx == `ICF_IDX_IRQ_STAT);
      hit_mask = (idx == `ICF_IDX_IRQ_MASK);
      // the enabling cycle counts as busy when the initial-start bit is 0
      busy_now = st.busy | (st.en & ~st.en_p & ~st.initial_start_enable_bit);
   end

   // read mux; unmapped words and unused bits read as zero
   always_comb begin
      rd = 32'h0000_0000;
      if (hit_flag) begin
         rd[`ICF_FLAG_FAIL]  = st.fail;
         rd[`ICF_FLAG_BUSY]  = st.busy;
         rd[`ICF_FLAG_INITIAL_START_ENABLE_BIT] = st.initial_start_enable_bit;
         rd[`ICF_FLAG_RSV]   = st.rsv;
      end else if (hit_ctrl) begin
         rd[`ICF_CTRL_EN]  = st.en;
         rd[`ICF_CTRL_STR] = st.str;
      end else if (hit_stat) begin
         rd[3:0] = st.irq_stat;
      end else if (hit_mask) begin
         rd[3:0] = st.irq_mask;
      end
   end

   // next state of the whole block
   always_comb begin
      next_st     = st;
      ev          = 4'h0;
      next_st.gen = 1'b0;

      // wishbone: ack one cycle after the request, dropped the next
      next_st.ack = req;
      if (req) begin
         next_st.rdata = rd;
      end

      // remember the enable so its rising edge can be seen
      next_st.en_p = st.en;

      // start request: a free bus lets the start go out at once; a
      // busy bus either keeps it reserved or fails it; a request written
      // together with the enable must not slip out before busy is set
      if (st.en && st.str) begin
         if (!busy_now) begin
            next_st.gen  = 1'b1;
            next_st.str  = 1'b0;
            next_st.busy = 1'b1;
            ev[`ICF_IRQ_GEN] = 1'b1;
         end else if (st.rsv) begin
            next_st.fail = 1'b1;
            next_st.str  = 1'b0;
            ev[`ICF_IRQ_FAIL] = 1'b1;
         end
      end

      // bus conditions seen on the lines
      if (cond.stop) begin
         next_st.busy = 1'b0;
         ev[`ICF_IRQ_STOP] = 1'b1;
      end
      if (cond.start) begin
         next_st.busy  = 1'b1;
         next_st.initial_start_enable_bit = 1'b0;
         ev[`ICF_IRQ_START] = 1'b1;
      end

      // enabling with the initial-start bit at 0 assumes a busy bus,
      // so no start goes out before a stop has been seen
      if (st.en && !st.en_p && !st.initial_start_enable_bit) begin
         next_st.busy = 1'b1;
      end

      // software writes; the start-failure flag clears only when no
      // new failure is being raised in the same cycle
      if (wr && hit_flag) begin
         next_st.initial_start_enable_bit = wbyte[`ICF_FLAG_INITIAL_START_ENABLE_BIT];
         next_st.rsv   = wbyte[`ICF_FLAG_RSV];
      end
      if (wr && hit_ctrl) begin
         next_st.en  = wbyte[`ICF_CTRL_EN];
         next_st.str = wbyte[`ICF_CTRL_STR];
         if (wbyte[`ICF_CTRL_STR] && !ev[`ICF_IRQ_FAIL]) begin
            next_st.fail = 1'b0;
         end
      end
      if (wr && hit_mask) begin
         next_st.irq_mask = wbyte[3:0];
      end

      // stopped operation: bus status and failure flag held at zero,
      // a pending request is dropped
      if (!st.en) begin
         next_st.busy = 1'b0;
         next_st.fail = 1'b0;
         if (!(wr && hit_ctrl && wbyte[`ICF_CTRL_EN])) begin
            next_st.str = 1'b0;
         end
      end

      // sticky status: a new event wins over a write-one-to-clear
      if (wr && hit_stat) begin
         next_st.irq_stat = st.irq_stat & ~wbyte[3:0];
      end
      next_st.irq_stat = next_st.irq_stat | ev;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   // one register for all state; synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st          <= '0;
         st.irq_stat <= `ICF_IRQ_RST;
         st.irq_mask <= `ICF_IRQ_RST;
      end else begin
         st <= next_st;
      end
   end

   // outputs, all from flops
   assign dat_o       = st.rdata;
   assign ack_o       = st.ack;
   assign start_gen_o = st.gen;
   assign busy_o      = st.busy;
   assign enable_o    = st.en;
   assign irq_o       = st.irq;

endmodule : icf_flags

// ==== sim/icf_flags_monitor.sv ====
// Purpose: port checks of the bus flag block
// Assumes: one clock domain, synchronous reset
// Notes:   bound into every icf_flags instance
`timescale 1ns/1ps
`include "icf_map.svh"
module icf_flags_monitor #(
   parameter int ADR_W = 18
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [ADR_W-1:0] adr_i,
   input  wire logic [31:0]      dat_o,
   input  wire logic             ack_o,
   // bus lines and controller side
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   input  wire logic             start_gen_o,
   input  wire logic             busy_o,
   input  wire logic             enable_o,
   input  wire logic             irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // handshake: one answer, one cycle late, never stretched
   wb_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   read_zero_a: assert property (
      ack_o && !we_i |-> dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   flag_rsvd_a: assert property (ack_o && !we_i &&
      adr_i[ADR_W-1:2] == `ICF_IDX_FLAG |-> dat_o[5:2] == 4'h0)
      else $error("flag bits 5..2 not zero");
   // a controller disabled for more than one cycle never reports a busy bus
   idle_off_a: assert property (
      !enable_o && !$past(enable_o) |-> !busy_o)
      else $error("busy while disabled");
   gen_free_a: assert property (
      start_gen_o |-> enable_o && !$past(busy_o))
      else $error("start made on a busy bus");
   // line conditions reach the flag within the sync delay
   stop_clear_a: assert property (
      scl_i && $rose(sda_i) |-> ##[1:6] !busy_o)
      else $error("stop did not free the bus");
   start_set_a: assert property (enable_o && scl_i && $fell(sda_i)
      |-> ##[1:6] busy_o) else $error("start did not mark busy");
   // main scenarios
   cover property (start_gen_o);
   cover property (irq_o);
   cover property (ack_o && !we_i && dat_o[7]);
endmodule : icf_flags_monitor

bind icf_flags icf_flags_monitor #(.ADR_W(ADR_W)) icf_flags_monitor_i (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_i), .sda_i(sda_i),
   .start_gen_o(start_gen_o), .busy_o(busy_o), .enable_o(enable_o),
   .irq_o(irq_o));

// ==== sim/icf_bus_peer.sv ====
// Purpose: another party on the two-wire bus making start and stop
// Assumes: lines idle high through pull-ups
// Notes:   its clock stands still between frames; half period 4 clocks
`timescale 1ns/1ps
module icf_bus_peer (
   // clock
   input  wire logic clk_i,
   // bus lines
   output logic      scl_o = 1'b1,
   output logic      sda_o = 1'b1
);
   // one line phase of 100 ns
   task automatic step(input logic c, input logic d);
      scl_o <= c;
      sda_o <= d;
      repeat (4) @(posedge clk_i);
   endtask : step
   // data falls while the clock is high
   task automatic start_c;
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : start_c
   // clock low first so that lowering data is no start
   task automatic stop_c;
      step(1'b0, sda_o);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop_c
endmodule : icf_bus_peer

// ==== sim/icf_flags_bench.sv ====
// Purpose: self-checking bench of the bus flag block
// Assumes: peer model drives the bus lines
// Notes:   register cases from a table, bus scenarios by hand
`timescale 1ns/1ps
`include "icf_map.svh"
module icf_flags_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [17:0] adr_i = 18'h00000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h00000000;
   logic [31:0] dat_o;
   logic        ack_o, scl_i, sda_i, start_gen_o, busy_o, enable_o, irq_o;
   logic [7:0]  rd;
   int          err_total = 0;
   int          tests_run = 0;
   int          gens = 0;
   // index, value written, value read back; last row is unmapped
   logic [31:0] rows [5] = '{{`ICF_IDX_FLAG, 16'hFF03},
      {`ICF_IDX_FLAG, 16'h0000}, {`ICF_IDX_IRQ_MASK, 16'hFA0A},
      {`ICF_IDX_IRQ_MASK, 16'h0000}, {16'h0000, 16'hFF00}};
   // 40 MHz clock and a count of starts handed on
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (start_gen_o === 1'b1) gens++;
   icf_flags #(.ADR_W(18)) icf_flags_i (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .scl_i(scl_i), .sda_i(sda_i), .start_gen_o(start_gen_o),
      .busy_o(busy_o), .enable_o(enable_o), .irq_o(irq_o));
   icf_bus_peer icf_bus_peer_i (.clk_i(clk_i), .scl_o(scl_i), .sda_o(sda_i));
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask : chk
   // classic cycle held until ack is sampled, then a cycle idle
   task automatic wb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (n == 20) chk("ack", 8'h00, 8'h01);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rdc(input logic [15:0] idx, input logic [7:0] e, string nm);
      wb(1'b0, idx, 8'h00);
      chk(nm, rd, e);
   endtask : rdc
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle
   task automatic results;
      if (err_total == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   // watchdog well beyond the expected run time
   initial begin
      #100000;
      err_total++;
      results;
   end
   // main sequence
   initial begin
      idle(3);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("outs",
          {start_gen_o, busy_o, enable_o, irq_o, 4'h0}, 8'h00);
      rdc(`ICF_IDX_FLAG, 8'h00, "flag rst");
      foreach (rows[i]) begin
         wb(1'b1, rows[i][31:16], rows[i][15:8]);
         rdc(rows[i][31:16], rows[i][7:0], "table");
      end
      // initial-start bit 0: busy on enable, start waits for a stop
      wb(1'b1, `ICF_IDX_CTRL, 8'h80);
      rdc(`ICF_IDX_FLAG, 8'h40, "busy on");
      chk("pins", {6'h0, busy_o, enable_o}, 8'h03);
      wb(1'b1, `ICF_IDX_CTRL, 8'h82);
      idle(10);
      chk("held", gens[7:0], 8'h00);
      icf_bus_peer_i.stop_c;
      idle(8);
      chk("after stop", gens[7:0], 8'h01);
      rdc(`ICF_IDX_CTRL, 8'h80, "str clr");
      rdc(`ICF_IDX_IRQ_STAT, 8'h0A, "irq stat");
      chk("irq masked", {7'h0, irq_o}, 8'h00);
      wb(1'b1, `ICF_IDX_IRQ_MASK, 8'h08);
      chk("irq up", {7'h0, irq_o}, 8'h01);
      wb(1'b1, `ICF_IDX_IRQ_STAT, 8'h08);
      chk("irq down", {7'h0, irq_o}, 8'h00);
      wb(1'b1, `ICF_IDX_CTRL, 8'h00);
      rdc(`ICF_IDX_FLAG, 8'h00, "busy off");
      // initial-start bit 1, no reservation; bus known idle here
      wb(1'b1, `ICF_IDX_FLAG, 8'h03);
      wb(1'b1, `ICF_IDX_CTRL, 8'h80);
      rdc(`ICF_IDX_FLAG, 8'h03, "free on");
      wb(1'b1, `ICF_IDX_CTRL, 8'h82);
      idle(4);
      chk("no wait", gens[7:0], 8'h02);
      icf_bus_peer_i.start_c;
      rdc(`ICF_IDX_FLAG, 8'h41, "start seen");
      wb(1'b1, `ICF_IDX_CTRL, 8'h82);
      rdc(`ICF_IDX_FLAG, 8'hC1, "fail");
      rdc(`ICF_IDX_CTRL, 8'h80, "str drop");
      wb(1'b1, `ICF_IDX_CTRL, 8'h00);
      rdc(`ICF_IDX_FLAG, 8'h01, "disabled");
      // enable and request in one write: busy at once, so the request fails and no start goes out
      wb(1'b1, `ICF_IDX_CTRL, 8'h82);
      rdc(`ICF_IDX_FLAG, 8'hC1, "en and str");
      chk("no early", gens[7:0], 8'h02);
      wb(1'b1, `ICF_IDX_CTRL, 8'h00);
      // second reset with the lines released
      icf_bus_peer_i.stop_c;
      rst_i <= 1'b1;
      idle(3);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(`ICF_IDX_FLAG, 8'h00, "flag rst2");
      results;
   end
endmodule : icf_flags_bench
